// >>> src/psd_defines.svh
// constants of the packed simd integer datapath
`ifndef PSD_DEFINES_SVH
`define PSD_DEFINES_SVH

`define PSD_DATA_W    64
`define PSD_HALF_W    32
`define PSD_REG_CNT   8
`define PSD_IDX_W     3
`define PSD_BE_W      8
`define PSD_BE_FULL   8'hFF
`define PSD_BE_LOW    8'h0F
`define PSD_BE_RST    8'h00
`define PSD_DATA_RST  64'h0000_0000_0000_0000
`define PSD_HALF_RST  32'h0000_0000
`define PSD_ADDR_W    64
`define PSD_ADDR_RST  64'h0000_0000_0000_0000
`define PSD_RD_PORTS  3
`define PSD_LANE_GRPS 3

`endif

// >>> src/psd_pkg.sv
// types shared by the packed simd integer datapath
`include "psd_defines.svh"

package psd_pkg;

   typedef enum logic [3:0] {
      PSD_OP_NOP      = 4'h0,
      PSD_OP_MOVE64   = 4'h1,
      PSD_OP_LOAD64   = 4'h3,
      PSD_OP_LOAD32   = 4'h2,
      PSD_OP_STORE64  = 4'h6,
      PSD_OP_STORE32  = 4'h7,
      PSD_OP_FROM_GPR = 4'h5,
      PSD_OP_TO_GPR   = 4'h4,
      PSD_OP_ADD      = 4'hC,
      PSD_OP_SUB      = 4'hD,
      PSD_OP_AND      = 4'hF,
      PSD_OP_ANDN     = 4'hE,
      PSD_OP_OR       = 4'hA,
      PSD_OP_XOR      = 4'hB
   } psd_op_t;

   typedef enum logic [1:0] {
      PSD_LANE_BYTE  = 2'h0,
      PSD_LANE_WORD  = 2'h1,
      PSD_LANE_DWORD = 2'h2
   } psd_lane_t;

   typedef enum logic [1:0] {
      PSD_WRAP = 2'h0,
      PSD_SSAT = 2'h1,
      PSD_USAT = 2'h2
   } psd_arith_t;

   typedef struct packed {
      logic                    valid;
      psd_op_t                 op;
      psd_lane_t               lane;
      psd_arith_t              arith;
      logic [`PSD_IDX_W-1:0]   dst;
      logic [`PSD_IDX_W-1:0]   srcA;
      logic [`PSD_IDX_W-1:0]   srcB;
      logic [`PSD_HALF_W-1:0]  gprData;
      logic [`PSD_ADDR_W-1:0]  gprAddr;
      logic [`PSD_DATA_W-1:0]  loadData;
   } psd_req_t;

   typedef struct packed {
      logic                    valid;
      logic [`PSD_ADDR_W-1:0]  addr;
      logic [`PSD_BE_W-1:0]    byteEn;
      logic [`PSD_DATA_W-1:0]  data;
   } psd_store_t;

   typedef struct packed {
      logic                    wrEn;
      logic [`PSD_IDX_W-1:0]   idx;
      logic [`PSD_DATA_W-1:0]  wrData;
   } psd_fview_t;

endpackage

// >>> src/psd_regfile.sv
// eight-entry register storage with registered write-first read ports
`timescale 1ns/10ps
`include "psd_defines.svh"

module psd_regfile #(
   parameter int DEPTH = `PSD_REG_CNT,
   parameter int WIDTH = `PSD_DATA_W,
   parameter int IDX_W = `PSD_IDX_W,
   parameter int PORTS = `PSD_RD_PORTS
) (
   input  wire logic                        clk,
   input  wire logic                        sys_rst,
   input  wire logic                        wrEn,
   input  wire logic [IDX_W-1:0]            wrIdx,
   input  wire logic [WIDTH-1:0]            wrData,
   input  wire logic [PORTS-1:0][IDX_W-1:0] rdIdx,
   output logic      [PORTS-1:0][WIDTH-1:0] rdData
);

   logic [WIDTH-1:0]             mem [DEPTH];
   logic [PORTS-1:0][WIDTH-1:0]  rdData_ff;
   logic [PORTS-1:0][WIDTH-1:0]  nxt_rdData;

   always_ff @(posedge clk) begin
      if (wrEn) begin
         mem[wrIdx] <= wrData;
      end
   end

   // write-first so a dependent request in the writeback cycle sees new data
   for (genvar p = 0; p < PORTS; p++) begin : g_rd
      always_comb begin
         if (wrEn && (wrIdx == rdIdx[p])) begin
            nxt_rdData[p] = wrData;
         end else begin
            nxt_rdData[p] = mem[rdIdx[p]];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdData_ff <= '0;
      end else begin
         rdData_ff <= nxt_rdData;
      end
   end

   assign rdData = rdData_ff;

endmodule

// >>> src/psd_datapath.sv
// packed simd integer datapath: register set, lane arithmetic, transfers
`timescale 1ns/10ps
`include "psd_defines.svh"

module psd_datapath #(
   parameter int DATA_W = `PSD_DATA_W,
   parameter int HALF_W = `PSD_HALF_W,
   parameter int IDX_W  = `PSD_IDX_W
) (
   input  wire logic                 clk,
   input  wire logic                 sys_rst,
   input  wire psd_pkg::psd_req_t    req,
   input  wire psd_pkg::psd_fview_t  floatReq,
   output logic                      floatWrReady,
   output logic      [DATA_W-1:0]    floatRdData,
   output logic                      resultValid,
   output logic      [DATA_W-1:0]    result,
   output logic                      gprOutValid,
   output logic      [HALF_W-1:0]    gprOut,
   output psd_pkg::psd_store_t       store,
   output logic                      procFlagsWrEn
);

   psd_pkg::psd_req_t                     s1_ff;
   psd_pkg::psd_req_t                     nxt_s1;
   logic [`PSD_RD_PORTS-1:0][IDX_W-1:0]   rdIdx;
   logic [`PSD_RD_PORTS-1:0][DATA_W-1:0]  rdData;
   logic [DATA_W-1:0]                     opA;
   logic [DATA_W-1:0]                     opB;
   logic [`PSD_LANE_GRPS-1:0][DATA_W-1:0] laneRes;
   logic [DATA_W-1:0]                     arithRes;
   logic [DATA_W-1:0]                     wbData;
   logic                                  wbEn;
   logic                                  isSub;
   logic                                  rfWrEn;
   logic [IDX_W-1:0]                      rfWrIdx;
   logic [DATA_W-1:0]                     rfWrData;

   logic                                  resultValid_ff;
   logic                                  nxt_resultValid;
   logic [DATA_W-1:0]                     result_ff;
   logic [DATA_W-1:0]                     nxt_result;
   logic                                  gprOutValid_ff;
   logic                                  nxt_gprOutValid;
   logic [HALF_W-1:0]                     gprOut_ff;
   logic [HALF_W-1:0]                     nxt_gprOut;
   psd_pkg::psd_store_t                   store_ff;
   psd_pkg::psd_store_t                   nxt_store;

   // stage 1 captures the request while the storage reads its sources
   always_comb begin
      nxt_s1 = req;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s1_ff <= '0;
      end else begin
         s1_ff <= nxt_s1;
      end
   end

   assign rdIdx[0] = req.srcA;
   assign rdIdx[1] = req.srcB;
   assign rdIdx[2] = floatReq.idx;

   // float stack view and packed view share one storage array
   psd_regfile #(
      .DEPTH (`PSD_REG_CNT),
      .WIDTH (DATA_W),
      .IDX_W (IDX_W),
      .PORTS (`PSD_RD_PORTS)
   ) u_regs (
      .clk     (clk),
      .sys_rst (sys_rst),
      .wrEn    (rfWrEn),
      .wrIdx   (rfWrIdx),
      .wrData  (rfWrData),
      .rdIdx   (rdIdx),
      .rdData  (rdData)
   );

   assign opA         = rdData[0];
   assign opB         = rdData[1];
   assign floatRdData = rdData[2];
   assign isSub       = (s1_ff.op == psd_pkg::PSD_OP_SUB);

   // one lane group per element size, each lane fully independent
   for (genvar g = 0; g < `PSD_LANE_GRPS; g++) begin : g_grp
      localparam int W = 8 << g;
      localparam int N = 8 >> g;
      for (genvar i = 0; i < N; i++) begin : g_lane
         logic [W-1:0] a;
         logic [W-1:0] b;
         logic [W:0]   ss;
         logic [W:0]   us;
         logic [W-1:0] r;
         assign a = opA[i*W +: W];
         assign b = opB[i*W +: W];
         always_comb begin
            if (isSub) begin
               ss = {a[W-1], a} - {b[W-1], b};
               us = {1'b0, a} - {1'b0, b};
            end else begin
               ss = {a[W-1], a} + {b[W-1], b};
               us = {1'b0, a} + {1'b0, b};
            end
            r = ss[W-1:0];
            if ((s1_ff.arith == psd_pkg::PSD_SSAT) && (g < 2) &&
                (ss[W] != ss[W-1])) begin
               r = ss[W] ? {1'b1, {(W-1){1'b0}}}
                         : {1'b0, {(W-1){1'b1}}};
            end else if ((s1_ff.arith == psd_pkg::PSD_USAT) && (g < 2) &&
                         us[W]) begin
               r = isSub ? {W{1'b0}} : {W{1'b1}};
            end
         end
         assign laneRes[g][i*W +: W] = r;
      end
   end

   always_comb begin
      unique case (s1_ff.lane)
         psd_pkg::PSD_LANE_BYTE:  arithRes = laneRes[0];
         psd_pkg::PSD_LANE_WORD:  arithRes = laneRes[1];
         psd_pkg::PSD_LANE_DWORD: arithRes = laneRes[2];
         default:                 arithRes = laneRes[0];
      endcase
   end

   // result select; nothing here depends on an execution mode
   always_comb begin
      wbEn   = s1_ff.valid;
      wbData = `PSD_DATA_RST;
      unique case (s1_ff.op)
         psd_pkg::PSD_OP_MOVE64:   wbData = opA;
         psd_pkg::PSD_OP_LOAD64:   wbData = s1_ff.loadData;
         psd_pkg::PSD_OP_LOAD32:   wbData = {`PSD_HALF_RST,
                                             s1_ff.loadData[HALF_W-1:0]};
         psd_pkg::PSD_OP_FROM_GPR: wbData = {`PSD_HALF_RST,
                                             s1_ff.gprData};
         psd_pkg::PSD_OP_ADD,
         psd_pkg::PSD_OP_SUB:      wbData = arithRes;
         psd_pkg::PSD_OP_AND:      wbData = opA & opB;
         psd_pkg::PSD_OP_ANDN:     wbData = ~opA & opB;
         psd_pkg::PSD_OP_OR:       wbData = opA | opB;
         psd_pkg::PSD_OP_XOR:      wbData = opA ^ opB;
         default:                  wbEn   = 1'b0;
      endcase
   end

   // packed writeback owns the port; the float view waits for a free cycle
   assign floatWrReady = ~wbEn;
   assign rfWrEn       = wbEn | floatReq.wrEn;
   assign rfWrIdx      = wbEn ? s1_ff.dst : floatReq.idx;
   assign rfWrData     = wbEn ? wbData : floatReq.wrData;

   always_comb begin
      nxt_resultValid = wbEn;
      nxt_result      = wbEn ? wbData : result_ff;
      nxt_gprOutValid = s1_ff.valid &&
                        (s1_ff.op == psd_pkg::PSD_OP_TO_GPR);
      nxt_gprOut      = nxt_gprOutValid ? opA[HALF_W-1:0] : gprOut_ff;
      nxt_store.valid = s1_ff.valid &&
                        ((s1_ff.op == psd_pkg::PSD_OP_STORE64) ||
                         (s1_ff.op == psd_pkg::PSD_OP_STORE32));
      nxt_store.addr  = s1_ff.gprAddr;
      nxt_store.data  = opA;
      if (s1_ff.op == psd_pkg::PSD_OP_STORE32) begin
         nxt_store.byteEn = `PSD_BE_LOW;
         nxt_store.data   = {`PSD_HALF_RST, opA[HALF_W-1:0]};
      end else begin
         nxt_store.byteEn = `PSD_BE_FULL;
      end
      if (!nxt_store.valid) begin
         nxt_store = store_ff;
         nxt_store.valid = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         resultValid_ff <= 1'b0;
         result_ff      <= `PSD_DATA_RST;
         gprOutValid_ff <= 1'b0;
         gprOut_ff      <= `PSD_HALF_RST;
         store_ff       <= '0;
      end else begin
         resultValid_ff <= nxt_resultValid;
         result_ff      <= nxt_result;
         gprOutValid_ff <= nxt_gprOutValid;
         gprOut_ff      <= nxt_gprOut;
         store_ff       <= nxt_store;
      end
   end

   assign resultValid   = resultValid_ff;
   assign result        = result_ff;
   assign gprOutValid   = gprOutValid_ff;
   assign gprOut        = gprOut_ff;
   assign store         = store_ff;
   assign procFlagsWrEn = 1'b0;

endmodule

// >>> verification/psd_datapath_props.sv
// port assertions for the packed simd datapath
`timescale 1ns/10ps
module psd_datapath_props (
   input wire logic                clk,
   input wire logic                sys_rst,
   input wire psd_pkg::psd_req_t   req,
   input wire logic                floatWrReady,
   input wire logic                resultValid,
   input wire logic [63:0]         result,
   input wire psd_pkg::psd_store_t store,
   input wire logic                procFlagsWrEn
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // requests that write a packed register
   wire wrOp = req.valid && !(req.op inside {4'h0, 4'h4, 4'h6, 4'h7,
      4'h8, 4'h9});
   a_flags_quiet: assert property (procFlagsWrEn == 1'b0)
      else $error("flag write seen");
   a_write_pulse: assert property (wrOp |-> ##2 resultValid)
      else $error("result pulse missing");
   a_no_extra: assert property (resultValid |-> $past(wrOp, 2))
      else $error("result pulse without request");
   a_load_pass: assert property (req.valid &&
      req.op == psd_pkg::PSD_OP_LOAD64 |->
      ##2 result == $past(req.loadData, 2)) else $error("load altered");
   a_gpr_half: assert property (req.valid &&
      req.op == psd_pkg::PSD_OP_FROM_GPR |->
      ##2 result == {32'h0, $past(req.gprData, 2)}) else $error("gpr in");
   a_store_full: assert property (req.valid &&
      req.op == psd_pkg::PSD_OP_STORE64 |-> ##2 store.valid &&
      store.byteEn == 8'hFF && store.addr == $past(req.gprAddr, 2))
      else $error("bad full store");
   a_store_half: assert property (req.valid &&
      req.op == psd_pkg::PSD_OP_STORE32 |-> ##2 store.valid &&
      store.byteEn == 8'h0F && store.data[63:32] == 32'h0)
      else $error("bad half store");
   a_port_busy: assert property (floatWrReady ==
      !($past(wrOp) && !$past(sys_rst))) else $error("float port");
endmodule

// >>> verification/psd_mem_model.sv
// memory side model: answers loads, takes stores
`timescale 1ns/10ps
module psd_mem_model (
   input  wire logic                clk,
   input  wire logic [63:0]         addr,
   input  wire psd_pkg::psd_store_t store,
   output logic      [63:0]         rdData
);
   logic [63:0] mem [16];
   initial for (int i = 0; i < 16; i++) mem[i] = {4{16'hA5C3 ^ 16'(i)}};
   assign rdData = mem[addr[6:3]];
   always @(posedge clk)
      if (store.valid)
         for (int j = 0; j < 8; j++)
            if (store.byteEn[j])
               mem[store.addr[6:3]][8*j +: 8] <= store.data[8*j +: 8];
endmodule

// >>> verification/testbench.sv
// self-checking bench of the packed simd datapath
`timescale 1ns/10ps
module testbench;
   logic                clk = 1'b0;
   logic                sys_rst = 1'b1;
   psd_pkg::psd_req_t   reqRaw, req;
   psd_pkg::psd_fview_t floatReq;
   psd_pkg::psd_store_t store;
   logic                floatWrReady, resultValid, gprOutValid, flagsWr;
   logic [63:0]         floatRdData, result, memData, v [8];
   logic [31:0]         gprOut, rv;
   logic [135:0]        qr[$], qg[$], qs[$];
   logic [135:0]        ex;
   int                  num_errors = 0, n_compared = 0, seed = 32'hD321;
   always #5 clk = ~clk;
   always_comb begin
      req = reqRaw;
      req.loadData = memData;
   end
   psd_datapath dut (.clk(clk), .sys_rst(sys_rst), .req(req),
      .floatReq(floatReq), .floatWrReady(floatWrReady),
      .floatRdData(floatRdData), .resultValid(resultValid),
      .result(result), .gprOutValid(gprOutValid), .gprOut(gprOut),
      .store(store), .procFlagsWrEn(flagsWr));
   psd_mem_model mem (.clk(clk), .addr(req.gprAddr), .store(store),
      .rdData(memData));
   task chk(input logic [135:0] e, input logic [135:0] g);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value at %0t: exp %h got %h", $time, e, g);
      end
   endtask
   task results;
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   function automatic logic [63:0] calc(psd_pkg::psd_op_t op,
      psd_pkg::psd_lane_t ln, psd_pkg::psd_arith_t ar,
      logic [63:0] a, b, ld, logic [31:0] g);
      int w;
      longint x, y, r, hi, lo;
      logic [63:0] o, m;
      w = 8 << ln;
      m = ~(64'hFFFF_FFFF_FFFF_FFFF << w);
      o = 64'h0;
      case (op)
         psd_pkg::PSD_OP_MOVE64:   return a;
         psd_pkg::PSD_OP_LOAD64:   return ld;
         psd_pkg::PSD_OP_LOAD32:   return {32'h0, ld[31:0]};
         psd_pkg::PSD_OP_FROM_GPR: return {32'h0, g};
         psd_pkg::PSD_OP_AND:      return a & b;
         psd_pkg::PSD_OP_ANDN:     return ~a & b;
         psd_pkg::PSD_OP_OR:       return a | b;
         psd_pkg::PSD_OP_XOR:      return a ^ b;
         default: ;
      endcase
      hi = ar == psd_pkg::PSD_SSAT ? (longint'(1) << (w - 1)) - 1 : m;
      lo = ar == psd_pkg::PSD_SSAT ? -hi - 1 : 0;
      for (int i = 0; i < 64 / w; i++) begin
         x = longint'((a >> (i * w)) & m);
         y = longint'((b >> (i * w)) & m);
         if (ar == psd_pkg::PSD_SSAT) begin
            x -= (x >> (w - 1)) << w;
            y -= (y >> (w - 1)) << w;
         end
         r = op == psd_pkg::PSD_OP_SUB ? x - y : x + y;
         if (ar != psd_pkg::PSD_WRAP && w < 32)
            r = r > hi ? hi : r < lo ? lo : r;
         o |= (64'(r) & m) << (i * w);
      end
      return o;
   endfunction
   task issue(input psd_pkg::psd_op_t op, input psd_pkg::psd_lane_t ln,
      input psd_pkg::psd_arith_t ar, input logic [2:0] d, a, b);
      logic [63:0] e;
      @(posedge clk);
      reqRaw <= '{1'b1, op, ln, ar, d, a, b, $random(seed),
         {2{$random(seed)}}, 64'h0};
      #1;
      e = calc(op, ln, ar, v[a], v[b], req.loadData, req.gprData);
      case (op)
         psd_pkg::PSD_OP_TO_GPR: qg.push_back(136'(v[a][31:0]));
         psd_pkg::PSD_OP_STORE64: qs.push_back({req.gprAddr, 8'hFF, v[a]});
         psd_pkg::PSD_OP_STORE32:
            qs.push_back({req.gprAddr, 8'h0F, 32'h0, v[a][31:0]});
         psd_pkg::PSD_OP_NOP, 4'h8, 4'h9: ;
         default: begin
            qr.push_back(136'(e));
            v[d] = e;
         end
      endcase
   endtask
   task fwr(input logic [2:0] i, input logic [63:0] d);
      int n;
      @(posedge clk);
      reqRaw.valid <= 1'b0;
      floatReq <= '{1'b1, i, d};
      for (n = 0; n < 9; n++) begin
         @(negedge clk);
         if (floatWrReady === 1'b1) break;
         @(posedge clk);
      end
      if (n == 9) begin
         num_errors++;
         results;
      end
      @(posedge clk) floatReq.wrEn <= 1'b0;
      v[i] = d;
   endtask
   always @(negedge clk) if (!sys_rst) begin
      if (resultValid) begin
         ex = qr.size() ? qr.pop_front() : 'x;
         chk(ex, 136'(result));
      end
      if (gprOutValid) begin
         ex = qg.size() ? qg.pop_front() : 'x;
         chk(ex, 136'(gprOut));
      end
      if (store.valid) begin
         ex = qs.size() ? qs.pop_front() : 'x;
         chk(ex, store[135:0]);
      end
   end
   initial begin
      reqRaw = '0;
      floatReq = '0;
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      @(negedge clk);
      chk(136'h0, 136'({resultValid, store.valid, flagsWr}));
      fwr(3'h0, 64'h7FFF_8000_7F80_FF00);
      fwr(3'h1, 64'h0001_FFFF_0180_0101);
      for (int i = 2; i < 8; i++) fwr(3'(i), {$random(seed), $random(seed)});
      for (int k = 0; k < 18; k++)
         issue(k < 9 ? psd_pkg::PSD_OP_ADD : psd_pkg::PSD_OP_SUB,
            psd_pkg::psd_lane_t'(k % 3), psd_pkg::psd_arith_t'((k / 3) % 3),
            3'h2, 3'h0, 3'h1);
      fwr(3'h5, 64'h0123_4567_89AB_CDEF);
      repeat (400) begin
         rv = $random(seed);
         issue(psd_pkg::psd_op_t'(rv[3:0]), psd_pkg::psd_lane_t'(rv[5:4] % 3),
            psd_pkg::psd_arith_t'(rv[7:6] % 3), rv[10:8], rv[13:11],
            rv[16:14]);
      end
      @(posedge clk) reqRaw.valid <= 1'b0;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk) floatReq.idx <= 3'(i);
         @(posedge clk);
         @(negedge clk) chk(136'(v[i]), 136'(floatRdData));
      end
      chk(136'h0, 136'(qr.size() + qg.size() + qs.size()));
      results;
   end
endmodule
bind psd_datapath psd_datapath_props u_props (.clk(clk), .sys_rst(sys_rst),
   .req(req), .floatWrReady(floatWrReady), .resultValid(resultValid),
   .result(result), .store(store), .procFlagsWrEn(procFlagsWrEn));
